// ---- design/adc_seq_pkg.sv ----
/*
  Shared constants and types for the converter sequencer: register map,
  control bit positions, reset values, conversion counts and carriers.
  Assumes an 8-bit register port and a machine-cycle strobe from the core.
*/
package adc_seq_pkg;

  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RESULT     = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h04;

  // Control register bit positions
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_DONE_BIT   = 4;
  localparam int CTRL_START_BIT  = 3;
  localparam int CTRL_RCSEL_BIT  = 2;
  localparam int CTRL_CH_HI_BIT  = 1;
  localparam int CTRL_CH_LO_BIT  = 0;

  // Interrupt status bit positions
  localparam int IRQ_DONE_BIT     = 0;
  localparam int IRQ_ABORT_BIT    = 1;
  localparam int STATUS_VALID_BIT = 7;
  localparam int IRQ_W            = 2;

  // Values after reset
  localparam logic [DATA_W-1:0] RESULT_RESET  = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_EN_RESET  = 2'h0;
  localparam logic [1:0]        CHANNEL_RESET = 2'h0;

  // Conversion counts
  localparam int CPU_CONV_MCYCLES    = 31;
  localparam int RC_SYNC_MIN_MCYCLES = 3;
  localparam int RC_SYNC_MAX_MCYCLES = 4;
  localparam int RC_CONV_CLKS        = 108;
  localparam int SAR_FIRST_TICK      = 4;
  localparam int SAR_BITS            = 8;
  localparam int TICK_CNT_W          = 7;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  // Controls towards the analog front end
  typedef struct packed {
    logic              powered;
    logic [1:0]        channel;
    logic [DATA_W-1:0] trial;
    logic              converting;
  } analog_ctl_s;

  // Sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_sync,
    st_conv
  } conv_state_e;

endpackage : adc_seq_pkg

// ---- design/adc_pin_sync.sv ----
/*
  Two-flop synchroniser for asynchronous level inputs.
  Assumes inputs are levels that stay put for several clock periods.
*/
`timescale 1ns/100ps
module adc_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         i_clk,  // System clock
  input  wire logic         i_srst, // Synchronous reset, active high
  input  wire logic [W-1:0] i_d,    // Asynchronous levels
  output logic      [W-1:0] o_q     // Synchronised levels
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_reg <= '0;
      o_q      <= '0;
    end else begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end

endmodule : adc_pin_sync

// ---- design/adc_conversion_sequencer.sv ----
/*
  Sequencer for an 8-bit successive-approximation converter: control,
  result and interrupt registers, CPU-clocked or RC-clocked timing,
  idle wake-up and power-down abort.
  Assumes a one-cycle machine-cycle strobe from the core, idle and
  power-down levels from the core, and i_clk running in power-down.
*/
// Functional notes
// R1 - After reset convert from machine-cycle clock; RC only when select bit set.
// R2 - CPU-clocked conversion completes exactly 31 machine cycles after start.
// R3 - System keeps CPU clock at 1 MHz or more for accuracy.
// R4 - Select bit set runs conversion from RC oscillator regardless of CPU clock.
// R5 - RC-clocked start spends 3 or 4 machine cycles synchronising.
// R6 - RC-clocked total lies between 3 mcycles+108 and 4 mcycles+112 RC clocks.
// R7 - Completion in idle with interrupt enabled wakes the CPU.
// R8 - RC-clocked conversion continues through power-down.
// R9 - Power-down during CPU-clocked conversion aborts, no wake, result invalid.
// R10 - Software enters idle or power-down within two machine cycles of start.
// R11 - System prevents other wake-ups until conversion finishes.
// R12 - Interrupt use: enable first, handler reads result, clears done and channel.
// R13 - Polled use: set channel, start, wait done, read, clear done and channel.
// R14 - Software enables converter long enough before any start.
// R15 - Start flag stays set during conversion; completion sets done flag.
// R16 - Start commands ignored while start or done flag is set.
// R17 - Result holds its value until another conversion starts.
// R18 - Two-bit channel selects input 0..3, writable only when both flags clear.
`timescale 1ns/100ps
module adc_conversion_sequencer #(
  parameter int CPU_MCYCLES = adc_seq_pkg::CPU_CONV_MCYCLES,
  parameter int RC_CLKS     = adc_seq_pkg::RC_CONV_CLKS
) (
  input  wire logic                           i_clk,        // 200 MHz system clock
  input  wire logic                           i_srst,       // Synchronous reset
  input  wire adc_seq_pkg::reg_req_s          i_bus,        // Register request
  output logic      [adc_seq_pkg::DATA_W-1:0] o_rdata,      // Read data, next cycle
  input  wire logic                           i_mcycle,     // Machine-cycle strobe
  input  wire logic                           i_idle,       // Core in idle
  input  wire logic                           i_power_down, // Core in power-down
  input  wire logic                           i_rc_osc,     // RC oscillator pin
  input  wire logic                           i_comp_hi,    // Input above trial level
  output adc_seq_pkg::analog_ctl_s            o_analog,     // Analog front-end control
  output logic                                o_irq,        // Level interrupt
  output logic                                o_wake        // Wake pulse to core
);

  localparam int CW = adc_seq_pkg::TICK_CNT_W;

  // Elaboration check on the conversion lengths
  if (CPU_MCYCLES > (1 << CW) - 1 || RC_CLKS > (1 << CW) - 1 ||
      CPU_MCYCLES < adc_seq_pkg::SAR_FIRST_TICK + adc_seq_pkg::SAR_BITS ||
      RC_CLKS < adc_seq_pkg::SAR_FIRST_TICK + adc_seq_pkg::SAR_BITS) begin : g_bad_len
    $error("conversion length out of range");
  end

  localparam logic [CW-1:0] CPU_LAST = CW'(CPU_MCYCLES - 1);
  localparam logic [CW-1:0] RC_LAST  = CW'(RC_CLKS - 1);
  localparam logic [CW-1:0] SAR_LO   = CW'(adc_seq_pkg::SAR_FIRST_TICK);
  localparam logic [CW-1:0] SAR_HI   = CW'(adc_seq_pkg::SAR_FIRST_TICK +
                                           adc_seq_pkg::SAR_BITS);
  localparam logic [2:0]    SYNC_MIN = 3'(adc_seq_pkg::RC_SYNC_MIN_MCYCLES);
  localparam logic [2:0]    SYNC_MAX = 3'(adc_seq_pkg::RC_SYNC_MAX_MCYCLES);

  // Write strobe aimed at one offset
  function automatic logic wr_hit(input adc_seq_pkg::reg_req_s req,
                                  input logic [adc_seq_pkg::ADDR_W-1:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction : wr_hit

  // Control, result and interrupt register fields, read data and wake
  logic                            enable_reg;
  logic                            start_flag_reg;
  logic                            done_flag_reg;
  logic                            rc_sel_reg;
  logic [1:0]                      channel_reg;
  logic [adc_seq_pkg::DATA_W-1:0]  result_reg;
  logic                            valid_reg;
  logic [adc_seq_pkg::IRQ_W-1:0]   irq_status_reg;
  logic [adc_seq_pkg::IRQ_W-1:0]   irq_enable_reg;
  logic [adc_seq_pkg::DATA_W-1:0]  rdata_reg;
  logic                            wake_reg;

  // Sequencer state
  adc_seq_pkg::conv_state_e        state_reg;
  logic [CW-1:0]                   tick_cnt_reg;
  logic [2:0]                      sync_cnt_reg;
  logic                            rc_seen_reg;
  logic [adc_seq_pkg::DATA_W-1:0]  sar_reg;
  logic [2:0]                      sar_step_reg;
  logic                            rc_prev_reg;

  // Synchronised pins
  logic [1:0]                      pin_sync;
  logic                            rc_level;
  logic                            comp_level;
  logic                            rc_tick;

  // Decoded events
  logic                            ctrl_wr;
  logic                            start_req;
  logic                            conv_tick;
  logic                            finish;
  logic                            abort;
  logic [CW-1:0]                   conv_last;
  logic [adc_seq_pkg::DATA_W-1:0]  sar_mask;

  // Oscillator and comparator pass two flops before use
  adc_pin_sync #(
    .W (2)
  ) u_pin_sync (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_d    ({i_rc_osc, i_comp_hi}),
    .o_q    (pin_sync)
  );

  assign rc_level   = pin_sync[1];
  assign comp_level = pin_sync[0];

  // Rising edge of the synchronised RC oscillator
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rc_prev_reg <= 1'b0;
    end else begin
      rc_prev_reg <= rc_level;
    end
  end

  assign rc_tick = rc_level & ~rc_prev_reg;

  // Start accepted only from the not-busy, not-complete state
  assign ctrl_wr   = wr_hit(i_bus, adc_seq_pkg::OFS_CTRL);
  assign start_req = ctrl_wr && i_bus.wdata[adc_seq_pkg::CTRL_START_BIT] &&
                     !start_flag_reg && !done_flag_reg &&                  // [R16]
                     (enable_reg || i_bus.wdata[adc_seq_pkg::CTRL_ENABLE_BIT]);

  // Conversion clock source: machine cycles by default, RC when selected
  assign conv_tick = rc_sel_reg ? rc_tick : i_mcycle;                      // [R1] [R4]
  assign conv_last = rc_sel_reg ? RC_LAST : CPU_LAST;                      // [R2] [R6]

  // Completion on the last conversion tick
  assign finish = (state_reg == adc_seq_pkg::st_conv) && conv_tick &&
                  (tick_cnt_reg == conv_last) && !abort;                   // [R2] [R6]

  // Power-down kills a CPU-clocked conversion only
  assign abort = (state_reg != adc_seq_pkg::st_idle) && i_power_down &&
                 !rc_sel_reg;                                              // [R9] [R8]

  // Bit under trial in the approximation
  assign sar_mask = 8'h80 >> sar_step_reg;

  // Sequencer state machine
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg    <= adc_seq_pkg::st_idle;
      tick_cnt_reg <= '0;
      sync_cnt_reg <= '0;
      rc_seen_reg  <= 1'b0;
    end else if (abort) begin
      state_reg    <= adc_seq_pkg::st_idle;                                 // [R9]
      tick_cnt_reg <= '0;
    end else begin
      case (state_reg)
        adc_seq_pkg::st_idle: begin
          tick_cnt_reg <= '0;
          sync_cnt_reg <= '0;
          rc_seen_reg  <= 1'b0;
          if (start_req) begin
            // RC select is taken as written with the start command
            if (i_bus.wdata[adc_seq_pkg::CTRL_RCSEL_BIT]) begin
              state_reg <= adc_seq_pkg::st_sync;                            // [R5]
            end else begin
              state_reg <= adc_seq_pkg::st_conv;                            // [R2]
            end
          end
        end
        adc_seq_pkg::st_sync: begin
          // Three machine cycles, a fourth when no RC edge was seen yet
          if (rc_tick) begin
            rc_seen_reg <= 1'b1;
          end
          if (i_mcycle) begin
            sync_cnt_reg <= sync_cnt_reg + 3'h1;
            if ((sync_cnt_reg + 3'h1 == SYNC_MIN && (rc_seen_reg || rc_tick)) ||
                sync_cnt_reg + 3'h1 == SYNC_MAX) begin
              state_reg <= adc_seq_pkg::st_conv;                            // [R5] [R6]
            end
          end
        end
        adc_seq_pkg::st_conv: begin
          if (conv_tick) begin
            tick_cnt_reg <= tick_cnt_reg + CW'(1);
            if (tick_cnt_reg == conv_last) begin
              state_reg <= adc_seq_pkg::st_idle;                            // [R15]
            end
          end
        end
        default: begin
          state_reg <= adc_seq_pkg::st_idle;
        end
      endcase
    end
  end

  // Successive approximation, one bit per conversion tick while the tick count is 4 to 11
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sar_reg      <= 8'h00;
      sar_step_reg <= 3'h0;
    end else if (start_req && state_reg == adc_seq_pkg::st_idle) begin
      sar_reg      <= 8'h80;
      sar_step_reg <= 3'h0;
    end else if (state_reg == adc_seq_pkg::st_conv && conv_tick &&
                 tick_cnt_reg >= SAR_LO && tick_cnt_reg < SAR_HI) begin
      sar_reg <= (comp_level ? sar_reg : (sar_reg & ~sar_mask)) | (sar_mask >> 1);
      sar_step_reg <= sar_step_reg + 3'h1;
    end
  end

  // Start and done flags; completion sets done over a software clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      start_flag_reg <= 1'b0;
      done_flag_reg  <= 1'b0;
    end else begin
      if (start_req) begin
        start_flag_reg <= 1'b1;                                             // [R15]
      end else if (finish || abort) begin
        start_flag_reg <= 1'b0;                                             // [R15] [R9]
      end
      if (finish) begin
        done_flag_reg <= 1'b1;                                              // [R15]
      end else if (ctrl_wr && !i_bus.wdata[adc_seq_pkg::CTRL_DONE_BIT]) begin
        done_flag_reg <= 1'b0;
      end
    end
  end

  // Enable, clock select and channel writes
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      enable_reg  <= 1'b0;
      rc_sel_reg  <= 1'b0;                                                  // [R1]
      channel_reg <= adc_seq_pkg::CHANNEL_RESET;
    end else if (ctrl_wr) begin
      // Enable cannot drop while a flag is set
      if (i_bus.wdata[adc_seq_pkg::CTRL_ENABLE_BIT] ||
          (!start_flag_reg && !done_flag_reg)) begin
        enable_reg <= i_bus.wdata[adc_seq_pkg::CTRL_ENABLE_BIT];
      end
      // Channel and select frozen while busy or complete
      if (!start_flag_reg && !done_flag_reg) begin
        rc_sel_reg  <= i_bus.wdata[adc_seq_pkg::CTRL_RCSEL_BIT];            // [R4]
        channel_reg <= i_bus.wdata[adc_seq_pkg::CTRL_CH_HI_BIT:
                                   adc_seq_pkg::CTRL_CH_LO_BIT];            // [R18]
      end
    end
  end

  // Result: cleared at start, loaded at completion, invalid after abort
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      result_reg <= adc_seq_pkg::RESULT_RESET;
      valid_reg  <= 1'b0;
    end else if (start_req) begin
      result_reg <= adc_seq_pkg::RESULT_RESET;                              // [R17]
      valid_reg  <= 1'b0;
    end else if (finish) begin
      result_reg <= sar_reg;                                                // [R17]
      valid_reg  <= 1'b1;
    end else if (abort) begin
      valid_reg  <= 1'b0;                                                   // [R9]
    end
  end

  // Sticky interrupt status; a new event beats a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg &
                         ~(wr_hit(i_bus, adc_seq_pkg::OFS_IRQ_CLEAR) ?
                           i_bus.wdata[adc_seq_pkg::IRQ_W-1:0] : '0)) |
                        {abort, finish};                                    // [R15] [R9]
    end
  end

  // Interrupt enable register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_enable_reg <= adc_seq_pkg::IRQ_EN_RESET;
    end else if (wr_hit(i_bus, adc_seq_pkg::OFS_IRQ_ENABLE)) begin
      irq_enable_reg <= i_bus.wdata[adc_seq_pkg::IRQ_W-1:0];
    end
  end

  // Wake the core at completion in idle, or in RC-clocked power-down, with the done interrupt enabled; an abort never wakes it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= finish && irq_enable_reg[adc_seq_pkg::IRQ_DONE_BIT] &&
                  (i_idle || (i_power_down && rc_sel_reg));                 // [R7] [R8] [R9]
    end
  end

  // Read data, valid in the cycle after the read strobe
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_reg <= '0;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        adc_seq_pkg::OFS_CTRL: begin
          rdata_reg <= {enable_reg, 2'b00, done_flag_reg, start_flag_reg,
                        rc_sel_reg, channel_reg};
        end
        adc_seq_pkg::OFS_RESULT: begin
          rdata_reg <= result_reg;
        end
        adc_seq_pkg::OFS_IRQ_STATUS: begin
          rdata_reg <= {valid_reg, 5'h00, irq_status_reg};
        end
        adc_seq_pkg::OFS_IRQ_ENABLE: begin
          rdata_reg <= {6'h00, irq_enable_reg};
        end
        default: begin
          rdata_reg <= '0;
        end
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  // Outputs
  assign o_rdata             = rdata_reg;
  assign o_irq               = |(irq_status_reg & irq_enable_reg);
  assign o_wake              = wake_reg;
  assign o_analog.powered    = enable_reg;
  assign o_analog.channel    = channel_reg;                                 // [R18]
  assign o_analog.trial      = sar_reg;
  assign o_analog.converting = (state_reg == adc_seq_pkg::st_conv);

endmodule : adc_conversion_sequencer

// ---- verification/adc_conversion_sequencer_properties.sv ----
/* Port checker for the converter sequencer.
   Assumes it is bound into adc_conversion_sequencer. */
`timescale 1ns/100ps
module adc_conversion_sequencer_properties (
  input wire logic                     i_clk,        // Clock
  input wire logic                     i_srst,       // Reset
  input wire adc_seq_pkg::reg_req_s    i_bus,        // Register request
  input wire logic [7:0]               o_rdata,      // Read data
  input wire adc_seq_pkg::analog_ctl_s o_analog,     // Front-end control
  input wire logic                     o_wake        // Wake pulse
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // Read data zero unless a read came before
  property p_rdata_idle; !$past(i_bus.rd) |-> o_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero");
  // Start write seen, not yet followed by a conversion (covers RC sync)
  logic start_pend_reg;
  always_ff @(posedge i_clk) begin
    if (i_srst || o_analog.converting) begin
      start_pend_reg <= 1'b0;
    end else if (i_bus.wr && i_bus.addr == adc_seq_pkg::OFS_CTRL) begin
      start_pend_reg <= i_bus.wdata[adc_seq_pkg::CTRL_START_BIT];
    end
  end
  // Conversion only starts after a control write with start set
  property p_start_cause; $rose(o_analog.converting) |-> start_pend_reg; endproperty
  a_start_cause: assert property (p_start_cause) else $error("start w/o write");
  // First trial code is mid scale
  property p_start_trial; $rose(o_analog.converting) |-> o_analog.trial == 8'h80; endproperty
  a_start_trial: assert property (p_start_trial) else $error("bad first trial");
  // Never converting while disabled
  property p_power_hold; o_analog.converting |-> o_analog.powered; endproperty
  a_power_hold: assert property (p_power_hold) else $error("converting unpowered");
  // Channel frozen during a conversion
  property p_chan_hold;
    o_analog.converting && $past(o_analog.converting) |-> $stable(o_analog.channel);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
  // Wake follows a finished conversion by one cycle
  property p_wake_after;
    o_wake |-> $past(o_analog.converting) && !o_analog.converting;
  endproperty
  a_wake_after: assert property (p_wake_after) else $error("wake w/o completion");
  // Wake is a single-cycle pulse
  property p_wake_pulse; o_wake |=> !o_wake; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
  // Converting never drops before it has stayed high for eight cycles after rising
  property p_conv_min; $rose(o_analog.converting) |=> o_analog.converting [*8]; endproperty
  a_conv_min: assert property (p_conv_min) else $error("conversion too short");
endmodule : adc_conversion_sequencer_properties

bind adc_conversion_sequencer adc_conversion_sequencer_properties u_props (
  .i_clk(i_clk), .i_srst(i_srst), .i_bus(i_bus), .o_rdata(o_rdata),
  .o_analog(o_analog), .o_wake(o_wake));

// ---- verification/adc_front_model.sv ----
/* Core strobe and analog front-end model.
   Assumes the input level is given as an 8-bit code. */
`timescale 1ns/100ps
module adc_front_model (
  input  wire logic       i_clk,     // Clock
  input  wire logic       i_srst,    // Reset
  input  wire logic [7:0] i_trial,   // Trial code
  input  wire logic [7:0] i_vin,     // Input level code
  output logic            o_mcycle,  // Machine-cycle strobe
  output logic            o_comp_hi, // Comparator out
  output logic            o_rc_osc   // RC clock
);
  logic [2:0] mc_cnt;
  // Machine cycle every six clocks, well above the accuracy floor
  always_ff @(posedge i_clk) begin
    mc_cnt   <= (i_srst || mc_cnt == 3'h5) ? 3'h0 : mc_cnt + 3'h1;
    o_mcycle <= !i_srst && mc_cnt == 3'h5;
  end
  // Comparator high when input at or above trial
  assign o_comp_hi = i_vin >= i_trial;
  // Free-running RC oscillator near 38 MHz, no other wake source
  initial begin
    o_rc_osc = 1'b0;
    forever #13 o_rc_osc = ~o_rc_osc;
  end
endmodule : adc_front_model

// ---- verification/adc_conversion_sequencer_tb.sv ----
/* Self-checking bench for the converter sequencer.
   Assumes the front-end model drives strobe, comparator and RC clock. */
`timescale 1ns/100ps
module adc_conversion_sequencer_tb;
  logic                     i_clk, i_srst, mcycle, idle, pd, rc_osc, comp_hi, irq, wake;
  adc_seq_pkg::reg_req_s    bus;
  adc_seq_pkg::analog_ctl_s analog;
  logic [7:0]               rdata, vin;
  int                       err_total, compares, mc_cnt, rc_cnt, sync_mc;
  logic                     w;
  logic [2:0]               rc_pipe;

  adc_conversion_sequencer u_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_bus(bus), .o_rdata(rdata), .i_mcycle(mcycle),
    .i_idle(idle), .i_power_down(pd), .i_rc_osc(rc_osc), .i_comp_hi(comp_hi),
    .o_analog(analog), .o_irq(irq), .o_wake(wake));
  adc_front_model u_front (
    .i_clk(i_clk), .i_srst(i_srst), .i_trial(analog.trial), .i_vin(vin),
    .o_mcycle(mcycle), .o_comp_hi(comp_hi), .o_rc_osc(rc_osc));

  // Clock, 5 ns period
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Count machine cycles and RC clocks while busy
  always @(posedge i_clk) if (analog.converting === 1'b1 && mcycle === 1'b1) mc_cnt++;
  // RC clocks as seen through two sampling flops on the system clock
  always @(posedge i_clk) begin
    rc_pipe <= {rc_pipe[1:0], rc_osc};
    if (analog.converting === 1'b1 && rc_pipe[1] === 1'b1 && rc_pipe[2] === 1'b0) rc_cnt++;
  end

  function automatic void chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endfunction : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk);
    bus <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge i_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk);
    bus <= '0;
    #1 chk(n, e, rdata);
  endtask : rd
  // Wait for the end of a conversion, then watch for a wake pulse
  task automatic wait_done(output logic seen);
    seen = 1'b0;
    repeat (4000) begin
      @(posedge i_clk);
      #1;
      if (analog.converting !== 1'b1) break;
    end
    if (analog.converting === 1'b1) begin
      err_total++;
      report_and_stop();
    end
    repeat (3) begin
      #1 seen |= wake;
      @(posedge i_clk);
    end
  endtask : wait_done
  task automatic report_and_stop;
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Values after reset and an unmapped read
  task automatic t_reset;
    rd(8'h00, 8'h00, "ctrl");
    rd(8'h01, 8'h00, "result");
    rd(8'h02, 8'h00, "status");
    rd(8'h03, 8'h00, "irq_en");
    rd(8'h07, 8'h00, "unmapped");
  endtask : t_reset
  // Polled CPU-clocked conversion with refused writes
  task automatic t_cpu;
    vin = 8'h5a;
    wr(8'h00, 8'h80);
    mc_cnt = 0;
    wr(8'h00, 8'h8b);
    wr(8'h00, 8'h88);
    chk("channel", 8'h03, {6'h00, analog.channel});
    wait_done(w);
    chk("mcycles", 8'(adc_seq_pkg::CPU_CONV_MCYCLES), 8'(mc_cnt));
    rd(8'h00, 8'h93, "ctrl_done");
    rd(8'h01, 8'h5a, "result");
    wr(8'h00, 8'h9b);
    rd(8'h00, 8'h93, "ctrl_refused");
    wr(8'h00, 8'h80);
    rd(8'h00, 8'h83, "ctrl_clr");
    wr(8'h00, 8'h80);
    rd(8'h00, 8'h80, "ctrl_idle");
    rd(8'h01, 8'h5a, "result_held");
  endtask : t_cpu
  // Idle with interrupt enabled: wake, mask and clear
  task automatic t_irq;
    vin = 8'hc3;
    wr(8'h03, 8'h01);
    @(posedge i_clk) idle <= 1'b1;
    wr(8'h00, 8'h89);
    wait_done(w);
    chk("wake", 8'h01, {7'h00, w});
    chk("irq", 8'h01, {7'h00, irq});
    rd(8'h02, 8'h81, "status");
    rd(8'h01, 8'hc3, "result");
    wr(8'h03, 8'h00);
    chk("irq_masked", 8'h00, {7'h00, irq});
    wr(8'h03, 8'h01);
    wr(8'h04, 8'h01);
    chk("irq_clr", 8'h00, {7'h00, irq});
    rd(8'h02, 8'h80, "status_clr");
    @(posedge i_clk) idle <= 1'b0;
    wr(8'h00, 8'h80);
    wr(8'h00, 8'h80);
  endtask : t_irq
  // RC clocked through power-down
  task automatic t_rc;
    vin = 8'h27;
    rc_cnt = 0;
    wr(8'h00, 8'h8e);
    sync_mc = 0;
    while (analog.converting !== 1'b1) begin
      @(posedge i_clk);
      pd <= 1'b1;
      if (mcycle === 1'b1) sync_mc++;
    end
    compares++;
    if (sync_mc < adc_seq_pkg::RC_SYNC_MIN_MCYCLES ||
        sync_mc > adc_seq_pkg::RC_SYNC_MAX_MCYCLES) begin
      err_total++;
      $display("ERROR sync_mcycles expected 3..4 seen %0d", sync_mc);
    end
    wait_done(w);
    compares++;
    if (rc_cnt < 108 || rc_cnt > 112) begin
      err_total++;
      $display("ERROR rc_clocks expected 108..112 seen %0d", rc_cnt);
    end
    chk("wake_pd", 8'h01, {7'h00, w});
    rd(8'h01, 8'h27, "result_rc");
    rd(8'h00, 8'h96, "ctrl_rc");
    @(posedge i_clk) pd <= 1'b0;
    wr(8'h04, 8'h01);
    wr(8'h00, 8'h80);
    wr(8'h00, 8'h80);
    rd(8'h00, 8'h80, "ctrl_cpu");
  endtask : t_rc
  // Power-down aborts a CPU-clocked conversion
  task automatic t_abort;
    wr(8'h03, 8'h03);
    wr(8'h00, 8'h88);
    repeat (20) @(posedge i_clk);
    pd <= 1'b1;
    wait_done(w);
    chk("wake_abort", 8'h00, {7'h00, w});
    chk("irq_abort", 8'h01, {7'h00, irq});
    rd(8'h02, 8'h02, "status_abort");
    rd(8'h00, 8'h80, "ctrl_abort");
    rd(8'h01, 8'h00, "result_abort");
    @(posedge i_clk) pd <= 1'b0;
    wr(8'h04, 8'h03);
    chk("irq_end", 8'h00, {7'h00, irq});
  endtask : t_abort

  // Watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    err_total = 0;
    compares  = 0;
    mc_cnt    = 0;
    rc_cnt    = 0;
    vin       = 8'h00;
    bus       = '0;
    idle      = 1'b0;
    pd        = 1'b0;
    i_srst    = 1'b1;
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset();
    t_cpu();
    t_irq();
    t_rc();
    t_abort();
    report_and_stop();
  end
endmodule : adc_conversion_sequencer_tb
